// ---- src/kbs_pkg.sv ----
// package for the keyboard switch and indicator block
package kbs_pkg;
    localparam int unsigned CLK_HZ       = 40_000_000;
    // mark is low, space is high on every logic data line
    localparam logic        MARK         = 1'b0;
    localparam logic        SPACE        = 1'b1;
    // space-detect minimum time
    localparam int unsigned SPACE_MS     = 5;
    localparam int unsigned SPACE_CYC    = (CLK_HZ / 1000) * SPACE_MS;
    // identifier release delay
    localparam int unsigned ID_REL_S     = 1;
    localparam int unsigned ID_REL_CYC   = CLK_HZ * ID_REL_S;
    // mark timeout range in seconds
    localparam int unsigned MARK_MIN_S   = 1;
    localparam int unsigned MARK_MAX_S   = 10;
    localparam int unsigned MARK_MAX_CYC = CLK_HZ * MARK_MAX_S;
    localparam int unsigned CNT_W        = 32;

    typedef enum logic [1:0] {
        KBS_RX,
        KBS_TX_DATA,
        KBS_TX_ID,
        KBS_ID_HOLD
    } kbs_state_t;

    typedef struct packed {
        logic mark_led;
        logic space_led;
        logic auto_led;
        logic loop_led;
        logic switch_led;
    } kbs_leds_t;
endpackage

// ---- src/kbs_timer.sv ----
// saturating run-length counter with a threshold compare
`timescale 1ns/10ps
module kbs_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              reached
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // count restarts whenever run drops, so only unbroken runs count
    assign cnt_d   = !run ? '0 : (cnt_q == limit) ? cnt_q : cnt_q + 1'b1;
    assign reached = run && (cnt_q == limit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule

// ---- src/kbs_top.sv ----
// keyboard operated switch, data merge, gating and front-panel indicators
`timescale 1ns/10ps
module kbs_top #(
    parameter int unsigned SPACE_CYCLES = kbs_pkg::SPACE_CYC,
    parameter int unsigned IDREL_CYCLES = kbs_pkg::ID_REL_CYC,
    parameter int unsigned SEC_CYCLES   = kbs_pkg::CLK_HZ
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    input  wire logic                RS232_DATA_IN,
    input  wire logic                MIL188_DATA_IN,
    input  wire logic                KEYBOARD_DATA_IN,
    input  wire logic                MORSE_IDENTIFIER_KEY,
    input  wire logic [3:0]          MARK_TIMEOUT_SEC,
    input  wire logic                SLICER_DATA,
    input  wire logic                AUTOSTART_PASS,
    input  wire logic                AUTOSTART_ENABLE,
    input  wire logic                STANDBY_N,
    input  wire logic                MOTOR_REQUEST,
    input  wire logic                LOOP_SENSE,
    input  wire logic                INTERFACE_DRIVE,
    output logic                     LOCAL_DATA,
    output logic                     GATED_RX_DATA,
    output logic                     MOTOR_ON,
    output logic                     RS232_DATA_OUT,
    output logic                     MIL188_DATA_OUT,
    output logic                     TRANSMIT,
    output kbs_pkg::kbs_leds_t       LEDS
);
    kbs_pkg::kbs_state_t st_q;
    kbs_pkg::kbs_state_t st_d;
    logic                local_d;
    logic                in_space;
    logic                in_mark;
    logic                space_hit;
    logic                mark_hit;
    logic                idrel_hit;
    logic                id_closed;
    logic                tx;
    logic                gate_open;
    logic                gated_d;
    logic [3:0]          tmo_sec;
    logic [kbs_pkg::CNT_W-1:0] mark_limit;
    kbs_pkg::kbs_leds_t  leds_d;

    // a space on any source wins the line, like a wired-or of contacts
    assign local_d   = RS232_DATA_IN | MIL188_DATA_IN | KEYBOARD_DATA_IN;
    assign in_space  = (LOCAL_DATA == kbs_pkg::SPACE);
    assign in_mark   = (LOCAL_DATA == kbs_pkg::MARK);
    assign id_closed = MORSE_IDENTIFIER_KEY;

    // out-of-range setting is clamped rather than trusted
    assign tmo_sec = (MARK_TIMEOUT_SEC < 4'(kbs_pkg::MARK_MIN_S)) ? 4'(kbs_pkg::MARK_MIN_S) :
                     (MARK_TIMEOUT_SEC > 4'(kbs_pkg::MARK_MAX_S)) ? 4'(kbs_pkg::MARK_MAX_S) :
                     MARK_TIMEOUT_SEC;
    assign mark_limit = kbs_pkg::CNT_W'(SEC_CYCLES * tmo_sec - 1);

    kbs_timer #(.W(kbs_pkg::CNT_W)) u_space (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .run     (in_space),
        .limit   (kbs_pkg::CNT_W'(SPACE_CYCLES - 1)),
        .reached (space_hit)
    );
    // the mark timer idles in receive, so a stale count never cuts a new transmit short
    kbs_timer #(.W(kbs_pkg::CNT_W)) u_mark (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .run     (in_mark && tx),
        .limit   (mark_limit),
        .reached (mark_hit)
    );
    kbs_timer #(.W(kbs_pkg::CNT_W)) u_idrel (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .run     (st_q == kbs_pkg::KBS_ID_HOLD && !id_closed),
        .limit   (kbs_pkg::CNT_W'(IDREL_CYCLES - 1)),
        .reached (idrel_hit)
    );

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            kbs_pkg::KBS_RX:
            begin
                if (id_closed)
                    st_d = kbs_pkg::KBS_TX_ID;
                else if (space_hit)
                    st_d = kbs_pkg::KBS_TX_DATA;
            end
            kbs_pkg::KBS_TX_DATA:
            begin
                if (id_closed)
                    st_d = kbs_pkg::KBS_TX_ID;
                else if (mark_hit)
                    st_d = kbs_pkg::KBS_RX;
            end
            kbs_pkg::KBS_TX_ID:
            begin
                if (!id_closed)
                    st_d = kbs_pkg::KBS_ID_HOLD;
            end
            kbs_pkg::KBS_ID_HOLD:
            begin
                // a full space run during the hold hands over to the data timeout
                if (id_closed)
                    st_d = kbs_pkg::KBS_TX_ID;
                else if (space_hit)
                    st_d = kbs_pkg::KBS_TX_DATA;
                else if (idrel_hit)
                    st_d = kbs_pkg::KBS_RX;
            end
            default:
                st_d = kbs_pkg::KBS_RX;
        endcase
    end

    // standby and a closed autostart gate both hold the printer at mark
    assign tx        = (st_q != kbs_pkg::KBS_RX);
    assign gate_open = AUTOSTART_PASS || !AUTOSTART_ENABLE;
    assign gated_d   = (tx || !STANDBY_N || !gate_open) ? kbs_pkg::MARK : SLICER_DATA;
    assign leds_d.mark_led  = (SLICER_DATA == kbs_pkg::MARK);
    assign leds_d.space_led = (gated_d == kbs_pkg::SPACE);
    assign leds_d.auto_led  = gate_open;
    assign leds_d.loop_led  = (LOOP_SENSE == kbs_pkg::MARK);
    assign leds_d.switch_led = (st_d != kbs_pkg::KBS_RX);

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q            <= kbs_pkg::KBS_RX;
            LOCAL_DATA      <= kbs_pkg::MARK;
            GATED_RX_DATA   <= kbs_pkg::MARK;
            MOTOR_ON        <= 1'b0;
            RS232_DATA_OUT  <= kbs_pkg::MARK;
            MIL188_DATA_OUT <= kbs_pkg::MARK;
            TRANSMIT        <= 1'b0;
            LEDS            <= '0;
        end
        else
        begin
            st_q            <= st_d;
            LOCAL_DATA      <= local_d;
            GATED_RX_DATA   <= gated_d;
            MOTOR_ON        <= tx || !STANDBY_N || MOTOR_REQUEST;
            RS232_DATA_OUT  <= INTERFACE_DRIVE;
            MIL188_DATA_OUT <= INTERFACE_DRIVE;
            TRANSMIT        <= (st_d != kbs_pkg::KBS_RX);
            LEDS            <= leds_d;
        end
    end

    a_space_enters_tx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (st_q == kbs_pkg::KBS_RX && !id_closed && space_hit) |=> TRANSMIT)
        else $error("space run did not start transmit");
    a_id_enters_tx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        id_closed |=> TRANSMIT)
        else $error("identifier key did not start transmit");
    a_no_early_tx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (st_q == kbs_pkg::KBS_RX && !id_closed && !space_hit) |=> !TRANSMIT)
        else $error("transmit without trigger");
    a_mark_timeout_rx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (st_q == kbs_pkg::KBS_TX_DATA && mark_hit && !id_closed) |=> !TRANSMIT)
        else $error("mark timeout did not return receive");
    a_id_release_rx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (st_q == kbs_pkg::KBS_ID_HOLD && idrel_hit && !id_closed && !space_hit) |=> !TRANSMIT)
        else $error("identifier release did not return receive");
    a_tx_gates_data: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        tx |=> (GATED_RX_DATA == kbs_pkg::MARK) && MOTOR_ON)
        else $error("receive data not held mark in transmit");
    a_iface_follow: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        RST_N |=> (RS232_DATA_OUT == $past(INTERFACE_DRIVE)) && (MIL188_DATA_OUT == $past(INTERFACE_DRIVE)))
        else $error("interface outputs do not follow drive");
    a_local_merge: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (RS232_DATA_IN || MIL188_DATA_IN || KEYBOARD_DATA_IN) |=> LOCAL_DATA == kbs_pkg::SPACE)
        else $error("space on a source lost from local data");
    a_switch_lamp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (LEDS.switch_led == tx) && (TRANSMIT == tx))
        else $error("switch lamp disagrees with transmit");
    // pin checks against $past inputs skip the edge that leaves reset, whose outputs still hold reset values
    a_mark_lamp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        RST_N |=> LEDS.mark_led == ($past(SLICER_DATA) == kbs_pkg::MARK))
        else $error("mark lamp wrong");
    a_space_lamp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        LEDS.space_led == (GATED_RX_DATA == kbs_pkg::SPACE))
        else $error("space lamp disagrees with gated data");
    a_auto_lamp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        RST_N |=> LEDS.auto_led == ($past(AUTOSTART_PASS) || !$past(AUTOSTART_ENABLE)))
        else $error("autostart lamp wrong");
    a_loop_lamp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        RST_N |=> LEDS.loop_led == ($past(LOOP_SENSE) == kbs_pkg::MARK))
        else $error("loop lamp wrong");

    c_tx_data: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        st_q == kbs_pkg::KBS_RX ##1 st_q == kbs_pkg::KBS_TX_DATA);
    c_tx_id: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        st_q == kbs_pkg::KBS_TX_ID ##1 st_q == kbs_pkg::KBS_ID_HOLD);
    c_id_rx: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        st_q == kbs_pkg::KBS_ID_HOLD ##1 st_q == kbs_pkg::KBS_RX);
    c_mark_rx: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        st_q == kbs_pkg::KBS_TX_DATA ##1 st_q == kbs_pkg::KBS_RX);
    c_hold_data: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        st_q == kbs_pkg::KBS_ID_HOLD ##1 st_q == kbs_pkg::KBS_TX_DATA);
endmodule

// ---- tb/kbs_station.sv ----
// keyboard and serial terminal model that keys start pulses onto one source
`timescale 1ns/10ps
module kbs_station (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] src,
    input  wire logic [7:0] space_len,
    input  wire logic       go,
    output logic [2:0]      data
);
    logic [7:0] left_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            left_q <= 8'h00;
        else if (go)
            left_q <= space_len;
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    // idle lines rest at mark so only keyed pulses reach the merge
    assign data = (left_q != 8'h00) ? (3'h1 << src) : {3{kbs_pkg::MARK}};
endmodule

// ---- tb/kbs_top_tb_top.sv ----
// self-checking bench for the keyboard switch and indicator block
`timescale 1ns/10ps
module kbs_top_tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] src = 2'h0;
    logic [7:0] len = 8'h00;
    logic       go = 1'b0;
    logic [2:0] kdat;
    logic       key = 1'b0, slicer = 1'b0, pass = 1'b0, auto_en = 1'b0, stby_n = 1'b1;
    logic       motor_req = 1'b0, loop_s = 1'b0, drive = 1'b0;
    logic [3:0] tmo = 4'h1;
    logic       local_d, gated, motor, rs_out, mil_out, tx;
    kbs_pkg::kbs_leds_t leds;
    int         errors = 0, checks = 0, cyc = 0;

    always #12.5 clk = ~clk;

    kbs_station kbs_station_inst (.clk(clk), .rst_n(rst_n), .src(src), .space_len(len), .go(go), .data(kdat));
    kbs_top #(.SPACE_CYCLES(20), .IDREL_CYCLES(50), .SEC_CYCLES(10)) kbs_top_inst (
        .REF_CLK(clk), .RST_N(rst_n), .RS232_DATA_IN(kdat[0]), .MIL188_DATA_IN(kdat[1]),
        .KEYBOARD_DATA_IN(kdat[2]), .MORSE_IDENTIFIER_KEY(key), .MARK_TIMEOUT_SEC(tmo),
        .SLICER_DATA(slicer), .AUTOSTART_PASS(pass), .AUTOSTART_ENABLE(auto_en), .STANDBY_N(stby_n),
        .MOTOR_REQUEST(motor_req), .LOOP_SENSE(loop_s), .INTERFACE_DRIVE(drive), .LOCAL_DATA(local_d),
        .GATED_RX_DATA(gated), .MOTOR_ON(motor), .RS232_DATA_OUT(rs_out), .MIL188_DATA_OUT(mil_out),
        .TRANSMIT(tx), .LEDS(leds));

    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic seen, input logic exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // settle one time unit past the edge so registered outputs have landed
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic send(input logic [1:0] s, input logic [7:0] n);
        @(posedge clk);
        src <= s;
        len <= n;
        go  <= 1'b1;
        @(posedge clk);
        go  <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            send(s[1:0], 8'h03);
            wait_n(2);
            chk("local_data", local_d, kbs_pkg::SPACE);
            wait_n(8);
        end
        chk("short_space_tx", tx, 1'b0);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk);
            drive  <= v[0];
            slicer <= v[0];
            loop_s <= v[0];
            wait_n(3);
            chk("rs232_out", rs_out, v[0]);
            chk("mil188_out", mil_out, v[0]);
            chk("mark_led", leds.mark_led, ~v[0]);
            chk("loop_led", leds.loop_led, ~v[0]);
        end
        @(posedge clk);
        auto_en <= 1'b1;
        pass    <= 1'b1;
        slicer  <= 1'b1;
        wait_n(40);
        chk("gated_open", gated, 1'b1);
        chk("space_led", leds.space_led, 1'b1);
        chk("auto_led_pass", leds.auto_led, 1'b1);
        chk("rx_no_trigger", tx, 1'b0);
        @(posedge clk);
        pass <= 1'b0;
        wait_n(3);
        chk("gated_closed", gated, 1'b0);
        chk("auto_led_closed", leds.auto_led, 1'b0);
        @(posedge clk);
        auto_en <= 1'b0;
        wait_n(3);
        chk("auto_led_off", leds.auto_led, 1'b1);
        chk("motor_idle", motor, 1'b0);
        // space of 30 cycles, longer than SPACE_CYCLES, on the local line, then the ten-cycle 1 s mark timeout
        send(2'h2, 8'd30);
        wait_n(20);
        chk("tx_space_early", tx, 1'b0);
        wait_n(1);
        chk("tx_space", tx, 1'b1);
        chk("switch_led_on", leds.switch_led, 1'b1);
        wait_n(1);
        chk("gated_tx", gated, 1'b0);
        chk("space_led_tx", leds.space_led, 1'b0);
        chk("motor_tx", motor, 1'b1);
        wait_n(18);
        chk("tx_short_mark", tx, 1'b1);
        wait_n(1);
        chk("tx_timeout_1s", tx, 1'b0);
        chk("switch_led_off", leds.switch_led, 1'b0);
        @(posedge clk);
        tmo <= 4'ha;
        send(2'h1, 8'd30);
        wait_n(130);
        chk("tx_mark_9s", tx, 1'b1);
        wait_n(1);
        chk("tx_timeout_10s", tx, 1'b0);
        @(posedge clk);
        key <= 1'b1;
        wait_n(1);
        chk("tx_key", tx, 1'b1);
        wait_n(150);
        chk("tx_key_held", tx, 1'b1);
        @(posedge clk);
        key <= 1'b0;
        wait_n(50);
        chk("tx_key_hold", tx, 1'b1);
        wait_n(1);
        chk("tx_key_release", tx, 1'b0);
        // a keyed space during the release hold hands over to the clamped mark timeout
        @(posedge clk);
        key <= 1'b1;
        tmo <= 4'hf;
        @(posedge clk);
        key <= 1'b0;
        send(2'h0, 8'd30);
        wait_n(80);
        chk("tx_hold_space", tx, 1'b1);
        wait_n(51);
        chk("tx_clamp_timeout", tx, 1'b0);
        @(posedge clk);
        motor_req <= 1'b1;
        wait_n(1);
        chk("motor_req", motor, 1'b1);
        @(posedge clk);
        motor_req <= 1'b0;
        stby_n    <= 1'b0;
        wait_n(1);
        chk("motor_standby", motor, 1'b1);
        chk("gated_standby", gated, 1'b0);
        tally_and_finish();
    end
endmodule
